// file: verilog/rsq_pkg.sv
`default_nettype none
package rsq_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFF_ICR = 8'h00;
  localparam logic [7:0] OFF_MASTER_IDLE_REGISTER = 8'h04;
  localparam logic [7:0] OFF_PERIPHERAL_IDLE_REGISTER = 8'h08;
  localparam logic [7:0] OFF_IDLE_STATUS_REGISTER = 8'h0c;
  localparam logic [7:0] OFF_XBCR = 8'h10;
  localparam logic [7:0] OFF_CLKSRC = 8'h14;
  localparam logic [7:0] OFF_BOOT = 8'h18;
  localparam logic [7:0] OFF_PLL = 8'h1c;
  localparam logic [7:0] OFF_GATE = 8'h20;
  // Idle control / status bit positions
  localparam int B_CPU = 0;
  localparam int B_MPORT = 1;
  localparam int B_ICACHE = 2;
  localparam int B_PERIPHERAL_DOMAIN_BIT = 3;
  localparam int B_CLKGEN = 4;
  localparam int B_EXTERNAL_MEMORY_INTERFACE = 5;
  localparam int B_IPORT = 6;
  // Master idle bits
  localparam int B_DMA = 0;
  localparam int B_HOST = 1;
  // Peripheral idle bit of the memory interface
  localparam int B_PEMIF = 13;
  // PLL control/status bits
  localparam int B_PLL_ENABLE_BIT = 0;
  localparam int B_PLLPD = 1;
  localparam int B_PLL_RESET_BIT = 2;
  localparam int B_OSCPD = 3;
  // Widths and reset values
  localparam int ICR_W = 10;
  localparam int PERIPHERAL_IDLE_REGISTER_W = 14;
  localparam int CNT_W = 17;
  localparam logic [3:0] PLL_RST_VAL = 4'h0;
  // Delay counts in reference clock cycles
  localparam int OSC_CYCLES = 41032;
  localparam int PROP_CYCLES = 70;
endpackage
`default_nettype wire

// file: verilog/reset_and_idle_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module reset_and_idle_sequencer #(
  parameter int OSC_COUNT = rsq_pkg::OSC_CYCLES,
  parameter int PROP_COUNT = rsq_pkg::PROP_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Straps and boot pins
  input wire logic CLOCK_SOURCE_STRAP,
  input wire logic PARALLEL_MUX_STRAP,
  input wire logic SERIAL_MUX_STRAP,
  input wire logic [2:0] BOOT_MODE_PINS,
  // Idle and wake events, activity
  input wire logic IDLE_EXEC,
  input wire logic WAKE,
  input wire logic DMA_ACTIVE,
  input wire logic [13:0] PERIPH_ACTIVE,
  // Reset release outputs
  output logic INTERRUPT_ACK_PIN_N,
  output logic CORE_RST_B,
  output logic PIN_OUT_EN,
  output logic PIN_HOLD,
  // Clock control
  output logic PLL_BYPASS,
  output logic CLOCK_SOURCE_SEL,
  output logic PLL_POWER_DOWN,
  output logic OSC_POWER_DOWN,
  output logic [6:0] DOMAIN_CLK_EN,
  output logic DMA_CLK_EN,
  output logic HOST_CLK_EN,
  output logic [13:0] PERIPH_CLK_EN,
  output logic SDRAM_REFRESH_EN,
  // Strap-loaded mux bits
  output logic PARALLEL_MUX_MODE,
  output logic SERIAL_MUX_MODE
);

  // Sequencer phases; codes 5 to 7 are illegal and fall back to capture
  typedef enum logic [2:0] {
    S_CAPT = 3'b000,
    S_COUNT = 3'b001,
    S_ACK = 3'b010,
    S_RUN = 3'b011,
    S_WAKE = 3'b100
  } state_t;

  // All state in one word so the reset and the update stay in step
  typedef struct packed {
    state_t state;
    logic [rsq_pkg::CNT_W-1:0] cnt;
    logic [rsq_pkg::ICR_W-1:0] idle_control_register;
    logic [1:0] master_idle_register;
    logic [rsq_pkg::PERIPHERAL_IDLE_REGISTER_W-1:0] peripheral_idle_register;
    logic [rsq_pkg::ICR_W-1:0] idle_status_register;
    logic [1:0] xbcr;
    logic clksrc;
    logic [2:0] boot;
    logic [3:0] pll;
    logic dma_off;
    logic external_memory_interface_off;
    logic [rsq_pkg::PERIPHERAL_IDLE_REGISTER_W-1:0] per_off;
    logic ack_n;
    logic core_rst_b;
    logic pin_oe;
    logic pin_hold;
    logic pll_pd;
    logic osc_pd;
    logic bypass;
    logic [6:0] dom_en;
    logic dma_en;
    logic host_en;
    logic [rsq_pkg::PERIPHERAL_IDLE_REGISTER_W-1:0] per_en;
    logic refresh;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
  } st_t;

  // Loads are one short: the edge that sees zero itself counts as a cycle
  localparam logic [rsq_pkg::CNT_W-1:0] OSC_N = rsq_pkg::CNT_W'(OSC_COUNT - 1);
  localparam logic [rsq_pkg::CNT_W-1:0] PROP_N = rsq_pkg::CNT_W'(PROP_COUNT - 1);
  localparam logic [rsq_pkg::CNT_W-1:0] BOTH_N =
    rsq_pkg::CNT_W'(OSC_COUNT + PROP_COUNT - 1);

  st_t r;
  st_t n;
  logic addr_ok;
  logic [7:0] a_off;
  logic full_off;
  logic dma_done;

  // Only the low byte decodes; the map repeats above it
  assign a_off = HADDR[7:0];
  assign addr_ok = HSEL & HTRANS[1] & HREADY;

  always_comb begin
    n = r;
    full_off = 1'b0;
    dma_done = 1'b0;
    unique case (r.state)
      // Straps are read once; later pin changes have no effect
      S_CAPT: begin
        n.xbcr = {SERIAL_MUX_STRAP, PARALLEL_MUX_STRAP};
        n.clksrc = CLOCK_SOURCE_STRAP;
        n.bypass = 1'b1;
        n.cnt = CLOCK_SOURCE_STRAP ? PROP_N : BOTH_N;
        n.state = S_COUNT;
      end

      // Core held until the loaded delay runs out; with CLOCK_SOURCE_STRAP set that is the propagation delay alone
      S_COUNT: begin
        if (r.cnt == '0) begin
          n.state = S_ACK;
          n.ack_n = 1'b0;
          n.core_rst_b = 1'b1;
          n.pin_oe = 1'b1;
          n.boot = BOOT_MODE_PINS;
          n.cnt = rsq_pkg::CNT_W'(1);
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end

      // Counter reused to time the acknowledge pulse
      S_ACK: begin
        if (r.cnt == '0) begin
          n.ack_n = 1'b1;
          n.state = S_RUN;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end

      // Wake has priority; a new idle needs status cleared first
      S_RUN: begin
        if (WAKE && r.idle_status_register != '0) begin
          if (r.osc_pd) begin
            n.cnt = OSC_N;
            n.state = S_WAKE;
          end else begin
            n.idle_status_register = '0;
            n.pll_pd = 1'b0;
            n.pin_hold = 1'b0;
          end
        end else if (IDLE_EXEC && r.idle_status_register == '0) begin
          n.idle_status_register = r.idle_control_register;
          if (r.idle_control_register[rsq_pkg::B_CLKGEN] && r.pll[rsq_pkg::B_PLLPD]) begin
            n.pll_pd = 1'b1;
            n.pin_hold = 1'b1;
            n.osc_pd = r.pll[rsq_pkg::B_OSCPD];
          end
        end
      end

      // Oscillator restart; propagation count is not added here
      S_WAKE: begin
        if (r.cnt == '0) begin
          n.idle_status_register = '0;
          n.osc_pd = 1'b0;
          n.pll_pd = 1'b0;
          n.pin_hold = 1'b0;
          n.pll[rsq_pkg::B_OSCPD] = 1'b0;
          n.state = S_RUN;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end

      default: n.state = S_CAPT;
    endcase

    // Bypass forced until the straps are in and while the PLL enable bit is clear
    if (r.pll[rsq_pkg::B_PLL_ENABLE_BIT] && r.state != S_CAPT) begin
      n.bypass = 1'b0;
    end else begin
      n.bypass = 1'b1;
    end

    // Register writes land in the data phase
    if (r.wr_pend) begin
      unique case (r.wr_addr)
        rsq_pkg::OFF_ICR: n.idle_control_register = HWDATA[rsq_pkg::ICR_W-1:0];
        rsq_pkg::OFF_MASTER_IDLE_REGISTER: n.master_idle_register = HWDATA[1:0];
        rsq_pkg::OFF_PERIPHERAL_IDLE_REGISTER: n.peripheral_idle_register = HWDATA[rsq_pkg::PERIPHERAL_IDLE_REGISTER_W-1:0];
        rsq_pkg::OFF_XBCR: n.xbcr = HWDATA[1:0];
        rsq_pkg::OFF_CLKSRC: n.clksrc = HWDATA[0];
        rsq_pkg::OFF_PLL: n.pll = HWDATA[3:0];
        default: n.wr_pend = 1'b0;
      endcase
    end
    n.wr_pend = addr_ok & HWRITE;
    n.wr_addr = a_off;

    // Gating; a stopped unit stays stopped until wake clears status
    if (n.idle_status_register == '0) begin
      n.dma_off = 1'b0;
      n.external_memory_interface_off = 1'b0;
      n.per_off = '0;
    end else begin
      if (r.idle_status_register[rsq_pkg::B_MPORT] && r.master_idle_register[rsq_pkg::B_DMA] && !DMA_ACTIVE) begin
        n.dma_off = 1'b1;
      end
      dma_done = !DMA_ACTIVE || r.dma_off;
      if (r.idle_status_register[rsq_pkg::B_EXTERNAL_MEMORY_INTERFACE] && dma_done) begin
        n.external_memory_interface_off = 1'b1;
      end
      if (r.idle_status_register[rsq_pkg::B_PERIPHERAL_DOMAIN_BIT] && r.peripheral_idle_register[rsq_pkg::B_PEMIF] && dma_done) begin
        n.external_memory_interface_off = 1'b1;
      end
      for (int i = 0; i < rsq_pkg::PERIPHERAL_IDLE_REGISTER_W; i++) begin
        if (r.idle_status_register[rsq_pkg::B_PERIPHERAL_DOMAIN_BIT] && r.peripheral_idle_register[i] && !PERIPH_ACTIVE[i]) begin
          n.per_off[i] = 1'b1;
        end
      end
    end

    // Deep idle overrides every per-unit enable
    full_off = n.pll_pd;
    n.dom_en = ~n.idle_status_register[6:0] & {7{~full_off}};
    n.dom_en[rsq_pkg::B_EXTERNAL_MEMORY_INTERFACE] = ~n.external_memory_interface_off & ~full_off;
    n.dma_en = ~n.dma_off & ~full_off;
    n.host_en = ~(n.idle_status_register[rsq_pkg::B_MPORT] & r.master_idle_register[rsq_pkg::B_HOST]) & ~full_off;
    n.per_en = ~n.per_off & {rsq_pkg::PERIPHERAL_IDLE_REGISTER_W{~full_off}};
    n.refresh = ~n.external_memory_interface_off & ~full_off;

    // Read data from next-state so a write just done reads back
    unique case (a_off)
      rsq_pkg::OFF_ICR: n.rdata = 32'(n.idle_control_register);
      rsq_pkg::OFF_MASTER_IDLE_REGISTER: n.rdata = 32'(n.master_idle_register);
      rsq_pkg::OFF_PERIPHERAL_IDLE_REGISTER: n.rdata = 32'(n.peripheral_idle_register);
      rsq_pkg::OFF_IDLE_STATUS_REGISTER: n.rdata = 32'(n.idle_status_register);
      rsq_pkg::OFF_XBCR: n.rdata = 32'(n.xbcr);
      rsq_pkg::OFF_CLKSRC: n.rdata = 32'(n.clksrc);
      rsq_pkg::OFF_BOOT: n.rdata = 32'(n.boot);
      rsq_pkg::OFF_PLL: n.rdata = 32'(n.pll);
      rsq_pkg::OFF_GATE: n.rdata = {n.per_en, 9'h000, n.host_en, n.dma_en, n.dom_en};
      default: n.rdata = 32'h0000_0000;
    endcase
    // Zero outside a read data phase so stale values never leak
    if (!(addr_ok && !HWRITE)) begin
      n.rdata = 32'h0000_0000;
    end
    // No wait states: every register answers at once
    n.ready = 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      // Clocks run and pins float while in reset
      r.state <= S_CAPT;
      r.cnt <= '0;
      r.idle_control_register <= '0;
      r.master_idle_register <= 2'h0;
      r.peripheral_idle_register <= '0;
      r.idle_status_register <= '0;
      r.xbcr <= 2'h0;
      r.clksrc <= 1'b0;
      r.boot <= 3'h0;
      r.pll <= rsq_pkg::PLL_RST_VAL;
      r.dma_off <= 1'b0;
      r.external_memory_interface_off <= 1'b0;
      r.per_off <= '0;
      r.ack_n <= 1'b1;
      r.core_rst_b <= 1'b0;
      r.pin_oe <= 1'b0;
      r.pin_hold <= 1'b0;
      r.pll_pd <= 1'b0;
      r.osc_pd <= 1'b0;
      r.bypass <= 1'b1;
      r.dom_en <= 7'h7f;
      r.dma_en <= 1'b1;
      r.host_en <= 1'b1;
      r.per_en <= 14'h3fff;
      r.refresh <= 1'b1;
      r.wr_pend <= 1'b0;
      r.wr_addr <= 8'h00;
      r.rdata <= 32'h0000_0000;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Every output but HRESP, which is tied low, is a plain register copy
  assign HRDATA = r.rdata;
  assign HREADYOUT = r.ready;
  assign HRESP = 1'b0;
  assign INTERRUPT_ACK_PIN_N = r.ack_n;
  assign CORE_RST_B = r.core_rst_b;
  assign PIN_OUT_EN = r.pin_oe;
  assign PIN_HOLD = r.pin_hold;
  assign PLL_BYPASS = r.bypass;
  assign CLOCK_SOURCE_SEL = r.clksrc;
  assign PLL_POWER_DOWN = r.pll_pd;
  assign OSC_POWER_DOWN = r.osc_pd;
  assign DOMAIN_CLK_EN = r.dom_en;
  assign DMA_CLK_EN = r.dma_en;
  assign HOST_CLK_EN = r.host_en;
  assign PERIPH_CLK_EN = r.per_en;
  assign SDRAM_REFRESH_EN = r.refresh;
  assign PARALLEL_MUX_MODE = r.xbcr[0];
  assign SERIAL_MUX_MODE = r.xbcr[1];

endmodule // reset_and_idle_sequencer
`default_nettype wire

// file: bench/rsq_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rsq_sva #(
  parameter int OSC_COUNT = 20,
  parameter int PROP_COUNT = 5
) (
  // Clock, reset and activity
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic IDLE_EXEC,
  input wire logic DMA_ACTIVE,
  input wire logic [13:0] PERIPH_ACTIVE,
  // Watched outputs
  input wire logic INTERRUPT_ACK_PIN_N,
  input wire logic CORE_RST_B,
  input wire logic PIN_OUT_EN,
  input wire logic PIN_HOLD,
  input wire logic CLOCK_SOURCE_SEL,
  input wire logic PLL_POWER_DOWN,
  input wire logic [6:0] DOMAIN_CLK_EN,
  input wire logic DMA_CLK_EN,
  input wire logic HOST_CLK_EN,
  input wire logic [13:0] PERIPH_CLK_EN,
  input wire logic SDRAM_REFRESH_EN
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // Edges since reset release, frozen once internal reset lifts
  logic [17:0] wait_reg;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) wait_reg <= 18'h0;
    else if (!CORE_RST_B) wait_reg <= wait_reg + 18'h1;
  end
  sequence ack_low_then_high;
    !INTERRUPT_ACK_PIN_N ##1 INTERRUPT_ACK_PIN_N;
  endsequence
  AST_COUNT: assert property ($rose(CORE_RST_B) |->
    wait_reg == (CLOCK_SOURCE_SEL ? PROP_COUNT + 1 : OSC_COUNT + PROP_COUNT + 1))
    else $error("release count wrong");
  AST_ACK: assert property ($fell(INTERRUPT_ACK_PIN_N) |=> ack_low_then_high)
    else $error("ack pulse not two cycles");
  AST_RELEASE: assert property ($rose(CORE_RST_B) |->
    $fell(INTERRUPT_ACK_PIN_N) && PIN_OUT_EN) else $error("release without ack");
  AST_HIZ: assert property (!CORE_RST_B |-> !PIN_OUT_EN && INTERRUPT_ACK_PIN_N)
    else $error("pins driven in reset");
  AST_HOST: assert property ($fell(HOST_CLK_EN) |-> $past(IDLE_EXEC))
    else $error("host clock stop late");
  AST_DMA: assert property ($fell(DMA_CLK_EN) |-> !$past(DMA_ACTIVE))
    else $error("dma stopped mid transfer");
  AST_PERIPH: assert property (
    ($past(PERIPH_CLK_EN) & ~PERIPH_CLK_EN & $past(PERIPH_ACTIVE)) == 14'h0)
    else $error("peripheral stopped while active");
  AST_REFRESH: assert property (!DOMAIN_CLK_EN[5] |-> !SDRAM_REFRESH_EN)
    else $error("refresh while memory idle");
  AST_DEEP: assert property (PLL_POWER_DOWN |-> DOMAIN_CLK_EN == 7'h0 && PIN_HOLD)
    else $error("deep idle clocks or pins");
endmodule // rsq_sva
bind reset_and_idle_sequencer rsq_sva #(.OSC_COUNT(OSC_COUNT), .PROP_COUNT(PROP_COUNT)) i_sva (
  .SYS_CLK, .RST_B, .IDLE_EXEC, .DMA_ACTIVE, .PERIPH_ACTIVE, .INTERRUPT_ACK_PIN_N,
  .CORE_RST_B, .PIN_OUT_EN, .PIN_HOLD, .CLOCK_SOURCE_SEL, .PLL_POWER_DOWN,
  .DOMAIN_CLK_EN, .DMA_CLK_EN, .HOST_CLK_EN, .PERIPH_CLK_EN, .SDRAM_REFRESH_EN);
`default_nettype wire

// file: bench/rsq_board.sv
`timescale 1ns/1ns
`default_nettype none
module rsq_board (
  // Bench control
  input wire logic SYS_CLK,
  input wire logic restart,
  input wire logic [5:0] cfg,
  // Board pins
  output logic RST_B,
  output logic CLOCK_SOURCE_STRAP,
  output logic PARALLEL_MUX_STRAP,
  output logic SERIAL_MUX_STRAP,
  output logic [2:0] BOOT_MODE_PINS
);
  logic [4:0] age_reg = 5'h0;
  always @(posedge SYS_CLK) begin
    if (restart) age_reg <= 5'h0;
    else if (age_reg != 5'h1f) age_reg <= age_reg + 5'h1;
  end
  // Straps are plain GPIO after sampling, so they flip to expose any resampling
  assign RST_B = age_reg >= 5'h0a;
  assign {CLOCK_SOURCE_STRAP, PARALLEL_MUX_STRAP, SERIAL_MUX_STRAP} =
    (age_reg > 5'h0b) ? ~cfg[2:0] : cfg[2:0];
  assign BOOT_MODE_PINS = cfg[5:3];
endmodule // rsq_board
`default_nettype wire

// file: bench/reset_and_idle_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module reset_and_idle_sequencer_bench;
  localparam int OSC = 20;
  localparam int PROP = 5;
  logic SYS_CLK = 1'b0;
  logic HSEL = 1'b0, HWRITE = 1'b0, IDLE_EXEC = 1'b0, WAKE = 1'b0, DMA_ACTIVE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2, BOOT_MODE_PINS;
  logic [13:0] PERIPH_ACTIVE = 14'h0, PERIPH_CLK_EN;
  logic restart = 1'b0;
  logic [5:0] cfg = 6'h0;
  logic HREADY, RST_B, CLOCK_SOURCE_STRAP, PARALLEL_MUX_STRAP, SERIAL_MUX_STRAP;
  logic HREADYOUT, HRESP, INTERRUPT_ACK_PIN_N, CORE_RST_B, PIN_OUT_EN, PIN_HOLD, PLL_BYPASS;
  logic CLOCK_SOURCE_SEL, PLL_POWER_DOWN, OSC_POWER_DOWN, DMA_CLK_EN, HOST_CLK_EN;
  logic SDRAM_REFRESH_EN, PARALLEL_MUX_MODE, SERIAL_MUX_MODE;
  logic [6:0] DOMAIN_CLK_EN;
  int bad_count = 0;
  int check_count = 0;
  assign HREADY = HREADYOUT;
  reset_and_idle_sequencer #(.OSC_COUNT(OSC), .PROP_COUNT(PROP)) i_dut (.*);
  rsq_board i_board (.*);
  initial forever #5 SYS_CLK = ~SYS_CLK;
  task automatic close_out;
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge SYS_CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADY !== 1'b1);
    q = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
    chk("resp", HRESP, 1'b0);
  endtask
  task automatic pulse(input logic w);
    if (w) WAKE <= 1'b1;
    else IDLE_EXEC <= 1'b1;
    tick(1);
    WAKE <= 1'b0;
    IDLE_EXEC <= 1'b0;
    tick(3);
  endtask
  task automatic idle(input logic [31:0] m, input logic [31:0] p, input logic [31:0] i);
    wr(rsq_pkg::OFF_MASTER_IDLE_REGISTER, m);
    wr(rsq_pkg::OFF_PERIPHERAL_IDLE_REGISTER, p);
    wr(rsq_pkg::OFF_ICR, i);
    tick(2);
    pulse(1'b0);
  endtask
  // Straps packed as {boot[2:0], clock, parallel, serial}
  task automatic boot(input logic [5:0] c);
    int k;
    k = 0;
    cfg <= c;
    restart <= 1'b1;
    tick(1);
    restart <= 1'b0;
    chk("bypass", PLL_BYPASS, 1'b1);
    chk("pins", PIN_OUT_EN, 1'b0);
    wait (RST_B === 1'b1);
    while (CORE_RST_B !== 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    chk("release", k, (c[2] ? PROP : OSC + PROP) + 1);
    chk("mux", {SERIAL_MUX_MODE, PARALLEL_MUX_MODE}, {c[0], c[1]});
    chk("ack", INTERRUPT_ACK_PIN_N, 1'b0);
    chk("clksel", CLOCK_SOURCE_SEL, c[2]);
    rd(rsq_pkg::OFF_XBCR, {30'h0, c[0], c[1]});
    rd(rsq_pkg::OFF_CLKSRC, {31'h0, c[2]});
    rd(rsq_pkg::OFF_BOOT, {29'h0, c[5:3]});
  endtask
  initial begin
    boot(6'h2a);
    wr(rsq_pkg::OFF_ICR, 32'hffffffff);
    rd(rsq_pkg::OFF_ICR, 32'h3ff);
    wr(rsq_pkg::OFF_IDLE_STATUS_REGISTER, 32'h5);
    rd(rsq_pkg::OFF_IDLE_STATUS_REGISTER, 32'h0);
    rd(8'h40, 32'h0);
    DMA_ACTIVE <= 1'b1;
    idle(32'h3, 32'h0, 32'h3);
    chk("host", HOST_CLK_EN, 1'b0);
    chk("dma", DMA_CLK_EN, 1'b1);
    chk("dom", DOMAIN_CLK_EN, 7'h7c);
    rd(rsq_pkg::OFF_IDLE_STATUS_REGISTER, 32'h3);
    rd(rsq_pkg::OFF_GATE, 32'hfffc00fc);
    DMA_ACTIVE <= 1'b0;
    tick(3);
    chk("dma", DMA_CLK_EN, 1'b0);
    pulse(1'b1);
    chk("host", HOST_CLK_EN & DMA_CLK_EN, 1'b1);
    rd(rsq_pkg::OFF_IDLE_STATUS_REGISTER, 32'h0);
    PERIPH_ACTIVE <= 14'h1;
    idle(32'h0, 32'h2001, 32'h8);
    chk("per", PERIPH_CLK_EN, 14'h1fff);
    PERIPH_ACTIVE <= 14'h0;
    tick(3);
    chk("per", PERIPH_CLK_EN, 14'h1ffe);
    pulse(1'b1);
    idle(32'h3, 32'h3fff, 32'h6f);
    chk("dom", DOMAIN_CLK_EN, 7'h10);
    chk("refresh", SDRAM_REFRESH_EN, 1'b0);
    chk("pll", PLL_POWER_DOWN, 1'b0);
    pulse(1'b1);
    chk("dom", DOMAIN_CLK_EN, 7'h7f);
    wr(rsq_pkg::OFF_PLL, 32'he);
    idle(32'h3, 32'h3fff, 32'h3ff);
    chk("pll", PLL_POWER_DOWN & OSC_POWER_DOWN, 1'b1);
    chk("hold", PIN_HOLD, 1'b1);
    chk("dom", DOMAIN_CLK_EN, 7'h0);
    pulse(1'b1);
    tick(OSC - 6);
    chk("dom", DOMAIN_CLK_EN, 7'h0);
    tick(8);
    chk("dom", DOMAIN_CLK_EN, 7'h7f);
    boot(6'h15);
    close_out();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule // reset_and_idle_sequencer_bench
`default_nettype wire
